// ### inc/dac_cfg.svh
// constants for the debug arm / trigger control block
// assumes inclusion by bare name from an inc/ search path
`ifndef DAC_CFG_SVH
`define DAC_CFG_SVH

// control register index; its byte address is four times the index
`define DAC_IDX_CTRL   6'h20
// byte offsets on the register bus
`define DAC_OFS_CTRL   {`DAC_IDX_CTRL, 2'h0}
`define DAC_OFS_IRQST  8'h40
`define DAC_OFS_IRQMSK 8'h44
`define DAC_OFS_SEQ    8'h48

// control register fields
`define DAC_B_ARM      7
`define DAC_B_IMMEDIATE_TRIGGER_REQUEST     6
`define DAC_B_BGSEL    4
`define DAC_B_FBRK     3
`define DAC_CTRL_RST   8'h00

// sequencer flag codes
`define DAC_SEQ_IDLE   3'h0
`define DAC_SEQ_FIRST  3'h1
`define DAC_SEQ_FINAL  3'h4

// bank select code with no comparator bank mapped
`define DAC_BANK_NONE  2'h3

// interrupt status bits
`define DAC_I_BKPT     0
`define DAC_I_END      1

// axi responses
`define DAC_RESP_OKAY  2'h0
`define DAC_RESP_SLV   2'h2

`endif

// ### inc/dac_pkg.sv
// types shared by the debug arm / trigger control block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package dac_pkg;

    typedef struct packed {
        logic        awrdy;
        logic        wrdy;
        logic        arrdy;
        logic        awhold;
        logic        whold;
        logic [7:0]  awaddr;
        logic [7:0]  wdata;
        logic        wstb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        arm;
        logic        bgsel;
        logic        fbrk;
        logic [1:0]  bank;
        logic        win_en;
        logic        mf_sel;
        logic [2:0]  seqst;
        logic        pend;
        logic        fire;
        logic        trace_req;
        logic [1:0]  ist;
        logic [1:0]  imask;
        logic        irq;
    } dac_st_t;

    typedef struct packed {
        logic bdm_req;
        logic swi_req;
    } dac_rt_t;

endpackage : dac_pkg
`default_nettype wire

// ### hdl/dac_bkpt_route.sv
// breakpoint routing to background mode or software interrupt
// assumes a one-cycle fire pulse and same-clock status levels
`default_nettype none
module dac_bkpt_route (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // request and routing controls
    input  wire logic fire,
    input  wire logic background_routing_select,
    input  wire logic background_mode_enable,
    input  wire logic background_active,
    // requests to the core
    output logic      bdm_req,
    output logic      swi_req
);

    dac_pkg::dac_rt_t s;
    dac_pkg::dac_rt_t next_s;

    always_comb begin
        next_s = '0;
        if (fire) begin
            if (background_routing_select) begin
                // disabled background mode falls back to software
                next_s.bdm_req = background_mode_enable;
                next_s.swi_req = !background_mode_enable;
            end else begin
                next_s.swi_req = !background_active;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign bdm_req = s.bdm_req;
    assign swi_req = s.swi_req;

endmodule : dac_bkpt_route
`default_nettype wire

// ### hdl/dac_ctrl.sv
// debug arm / trigger control register with axi4-lite slave
// assumes sequencer, trace and background status on the same clock
`include "dac_cfg.svh"
`default_nettype none
// Operation
// - session flag and bank selector accept writes at any time.
// - trigger bit always writable; it always reads back zero.
// - routing select and final breakpoint enable writable only while disarmed.
// - session flag set/cleared by software, self-clears on trace end or breakpoint.
// - writing one arms and enters first state; zero disarms.
// - trigger one forces final state regardless of comparators; zero does nothing.
// - after triggered tracing completes, breakpoint may follow per enable and routing.
// - trigger with trace source clear records no trace data.
// - trigger ignored once begin-aligned tracing has started.
// - secure mode disables tracing; trigger cannot start a session.
// - routing one: background mode if enabled, else software interrupt.
// - routing zero: software interrupt if background inactive, else nothing.
// - enable set with tracing: breakpoint waits for trace completion.
// - enable set without tracing: breakpoint at once; clear: no breakpoint.
// - selector codes 00-10 map banks A-C into window; 11 maps none.
// - selector picks state control A-C or match flags at shared address.
// - while armed only session, trigger and selector bits are writable.
// - arming sets flags 001; internal end clears; software disarm keeps them.
module dac_ctrl (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // sequencer and trace status
    input  wire logic        seq_step,
    input  wire logic [2:0]  seq_step_state,
    input  wire logic        trace_source_enable,
    input  wire logic        trigger_alignment,
    input  wire logic        trace_begun,
    input  wire logic        trace_complete,
    input  wire logic        secure_mode,
    // background module status
    input  wire logic        background_mode_enable,
    input  wire logic        background_active,
    // outputs to sequencer, trace and map
    output logic             armed,
    output logic [2:0]       sequencer_state_flags,
    output logic             trace_trigger,
    output logic [1:0]       comparator_bank_select,
    output logic             window_map_enable,
    output logic             match_flag_select,
    // breakpoint requests and interrupt
    output logic             bdm_req,
    output logic             software_interrupt,
    output logic             irq
);

    dac_pkg::dac_st_t s;
    dac_pkg::dac_st_t next_s;

    logic       tracing;
    logic       wr_go;
    logic       wr_ctrl;
    logic       ar_go;
    logic       reach;
    logic       ignore_immediate_trigger_request;
    logic [1:0] ev;

    // tracing never runs in secure mode
    assign tracing     = trace_source_enable && !secure_mode;
    assign wr_go       = s.awhold && s.whold && !s.bvalid;
    assign wr_ctrl     = wr_go && s.wstb && (s.awaddr == `DAC_OFS_CTRL);
    assign ar_go       = s_axi_arvalid && s.arrdy;
    assign ignore_immediate_trigger_request = trace_begun && trigger_alignment;

    always_comb begin
        next_s           = s;
        next_s.fire      = 1'b0;
        next_s.trace_req = 1'b0;
        reach            = 1'b0;
        ev               = 2'h0;

        // write address and data, taken in either order
        if (s_axi_awvalid && s.awrdy) begin
            next_s.awhold = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wrdy) begin
            next_s.whold = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wstb  = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // sequencer advance while armed
        if (s.arm && seq_step && s.seqst != `DAC_SEQ_FINAL) begin
            next_s.seqst = seq_step_state;
        end

        // tracing session completes: internal end
        if (s.arm && tracing && trace_complete) begin
            next_s.arm  = 1'b0;
            next_s.seqst = `DAC_SEQ_IDLE;
            next_s.fire = s.pend;
            next_s.pend = 1'b0;
            ev[`DAC_I_END] = 1'b1;
        end

        // software writes: response, control register and interrupt mask
        if (wr_go) begin
            next_s.awhold = 1'b0;
            next_s.whold  = 1'b0;
            next_s.bvalid = 1'b1;
            if (s.awaddr == `DAC_OFS_CTRL || s.awaddr == `DAC_OFS_IRQST ||
                s.awaddr == `DAC_OFS_IRQMSK || s.awaddr == `DAC_OFS_SEQ) begin
                next_s.bresp = `DAC_RESP_OKAY;
            end else begin
                next_s.bresp = `DAC_RESP_SLV;
            end
        end
        if (wr_ctrl) begin
            next_s.bank = s.wdata[1:0];
            // armed state locks these, so a disarming write leaves them
            if (!s.arm) begin
                next_s.bgsel = s.wdata[`DAC_B_BGSEL];
                next_s.fbrk  = s.wdata[`DAC_B_FBRK];
            end
            if (s.wdata[`DAC_B_ARM] && !s.arm) begin
                next_s.arm  = 1'b1;
                next_s.seqst = `DAC_SEQ_FIRST;
                next_s.pend = 1'b0;
            end else if (!s.wdata[`DAC_B_ARM]) begin
                next_s.arm  = 1'b0;
                next_s.pend = 1'b0;
            end
            if (s.wdata[`DAC_B_IMMEDIATE_TRIGGER_REQUEST] && next_s.arm && !ignore_immediate_trigger_request) begin
                next_s.seqst = `DAC_SEQ_FINAL;
            end
        end
        if (wr_go && s.wstb && s.awaddr == `DAC_OFS_IRQMSK) begin
            next_s.imask = s.wdata[1:0];
        end

        // reaching the final state
        reach = next_s.arm && next_s.seqst == `DAC_SEQ_FINAL && s.seqst != `DAC_SEQ_FINAL;
        if (reach) begin
            next_s.trace_req = tracing;
            if (next_s.fbrk && tracing) begin
                next_s.pend = 1'b1;
            end else if (next_s.fbrk) begin
                next_s.fire = 1'b1;
                next_s.arm  = 1'b0;
                next_s.seqst = `DAC_SEQ_IDLE;
                ev[`DAC_I_END] = 1'b1;
            end
        end
        ev[`DAC_I_BKPT] = next_s.fire;

        // sticky status: a new event beats a same-cycle clear
        if (wr_go && s.wstb && s.awaddr == `DAC_OFS_IRQST) begin
            next_s.ist = s.ist & ~s.wdata[1:0];
        end
        next_s.ist = next_s.ist | ev;
        next_s.irq = |(next_s.ist & next_s.imask);

        // read channel
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (ar_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = `DAC_RESP_OKAY;
            case (s_axi_araddr)
                `DAC_OFS_CTRL: begin
                    // trigger position is write-only and reads zero
                    next_s.rdata = {24'h000000, s.arm, 1'b0, 1'b0, s.bgsel,
                                    s.fbrk, 1'b0, s.bank};
                end
                `DAC_OFS_IRQST: begin
                    next_s.rdata = {30'h00000000, s.ist};
                end
                `DAC_OFS_IRQMSK: begin
                    next_s.rdata = {30'h00000000, s.imask};
                end
                `DAC_OFS_SEQ: begin
                    next_s.rdata = {24'h000000, s.arm, 4'h0, s.seqst};
                end
                default: begin
                    next_s.rdata = 32'h00000000;
                    next_s.rresp = `DAC_RESP_SLV;
                end
            endcase
        end

        // map selection follows the bank selector
        next_s.win_en = next_s.bank != `DAC_BANK_NONE;
        next_s.mf_sel = next_s.bank == `DAC_BANK_NONE;

        next_s.awrdy = !next_s.awhold && !next_s.bvalid;
        next_s.wrdy  = !next_s.whold && !next_s.bvalid;
        next_s.arrdy = !next_s.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    dac_bkpt_route u_dac_bkpt_route (
        .aclk                      (aclk),
        .aresetn                   (aresetn),
        .fire                      (s.fire),
        .background_routing_select (s.bgsel),
        .background_mode_enable    (background_mode_enable),
        .background_active         (background_active),
        .bdm_req                   (bdm_req),
        .swi_req                   (software_interrupt)
    );

    assign s_axi_awready          = s.awrdy;
    assign s_axi_wready           = s.wrdy;
    assign s_axi_bvalid           = s.bvalid;
    assign s_axi_bresp            = s.bresp;
    assign s_axi_arready          = s.arrdy;
    assign s_axi_rvalid           = s.rvalid;
    assign s_axi_rresp            = s.rresp;
    assign s_axi_rdata            = s.rdata;
    assign armed                  = s.arm;
    assign sequencer_state_flags  = s.seqst;
    assign trace_trigger          = s.trace_req;
    assign comparator_bank_select = s.bank;
    assign window_map_enable      = s.win_en;
    assign match_flag_select      = s.mf_sel;
    assign irq                    = s.irq;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_internal_end;
        !s.arm && s.seqst == `DAC_SEQ_IDLE;
    endsequence

    sequence s_fired_end;
        s.fire && !s.arm ##0 s_internal_end;
    endsequence

    property p_immediate_trigger_request_reads_zero;
        ar_go && s_axi_araddr == `DAC_OFS_CTRL |=> s_axi_rvalid && !s_axi_rdata[6];
    endproperty
    a_immediate_trigger_request_reads_zero: assert property (p_immediate_trigger_request_reads_zero)
        else $error("trigger bit read back as one");

    property p_bank_any_time;
        wr_ctrl |=> s.bank == $past(s.wdata[1:0]) ##1 window_map_enable == (s.bank != 2'h3);
    endproperty
    a_bank_any_time: assert property (p_bank_any_time)
        else $error("bank selector write lost");

    property p_locked_when_armed;
        wr_ctrl && s.arm |=> $stable({s.bgsel, s.fbrk});
    endproperty
    a_locked_when_armed: assert property (p_locked_when_armed)
        else $error("locked field changed while armed");

    property p_arm_first_state;
        wr_ctrl && !s.arm && s.wdata[7] && !s.wdata[6] && !seq_step
            |=> armed && sequencer_state_flags == 3'h1;
    endproperty
    a_arm_first_state: assert property (p_arm_first_state)
        else $error("arming did not enter first state");

    property p_sw_disarm_keeps;
        wr_ctrl && s.arm && !s.wdata[7] && !(tracing && trace_complete) && !seq_step
            |=> !armed && $stable(s.seqst);
    endproperty
    a_sw_disarm_keeps: assert property (p_sw_disarm_keeps)
        else $error("software disarm changed state flags");

    property p_immediate_bkpt;
        s.arm && s.fbrk && !tracing && s.seqst != 3'h4 && seq_step
            && seq_step_state == 3'h4 && !wr_ctrl |=> s_fired_end;
    endproperty
    a_immediate_bkpt: assert property (p_immediate_bkpt)
        else $error("breakpoint not issued at final state");

    property p_wait_trace;
        s.pend && s.arm && !trace_complete |=> !s.fire;
    endproperty
    a_wait_trace: assert property (p_wait_trace)
        else $error("breakpoint issued before trace completion");

    property p_trace_done_bkpt;
        s.arm && s.pend && tracing && trace_complete && !wr_ctrl
            |=> s_fired_end ##1 (bdm_req || software_interrupt || background_active);
    endproperty
    a_trace_done_bkpt: assert property (p_trace_done_bkpt)
        else $error("no breakpoint after trace completion");

    property p_secure_no_trace;
        secure_mode |=> !trace_trigger;
    endproperty
    a_secure_no_trace: assert property (p_secure_no_trace)
        else $error("trace started in secure mode");

    property p_route_swi;
        s.fire && !s.bgsel && background_active |=> !bdm_req && !software_interrupt;
    endproperty
    a_route_swi: assert property (p_route_swi)
        else $error("breakpoint produced while background active");

    property p_route_bdm;
        s.fire && s.bgsel |=> bdm_req == $past(background_mode_enable)
            && software_interrupt == !$past(background_mode_enable);
    endproperty
    a_route_bdm: assert property (p_route_bdm)
        else $error("background routing wrong");

endmodule : dac_ctrl
`default_nettype wire

// ### verification/dac_core_model.sv
// model of the core and background debug side that takes breakpoint requests
// assumes one-cycle request pulses on aclk; background state set by the bench
`default_nettype none
module dac_core_model (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // background module settings chosen by a scenario
    input  wire logic cfg_enable,
    input  wire logic cfg_active,
    // requests from the debug block
    input  wire logic bdm_req,
    input  wire logic software_interrupt,
    // background status back to the debug block
    output logic      background_mode_enable,
    output logic      background_active,
    // request tallies
    output var int    n_bdm,
    output var int    n_swi
);
    timeunit 1ns;
    timeprecision 1ps;

    // active without enable cannot happen on the real part, so never shown
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            background_mode_enable <= 1'h0;
            background_active      <= 1'h0;
            n_bdm                  <= 0;
            n_swi                  <= 0;
        end else begin
            background_mode_enable <= cfg_enable;
            background_active      <= cfg_enable & cfg_active;
            if (bdm_req === 1'h1) n_bdm <= n_bdm + 1;
            if (software_interrupt === 1'h1) n_swi <= n_swi + 1;
        end
    end
endmodule : dac_core_model
`default_nettype wire

// ### verification/debug_arm_trigger_control_bench.sv
// self-checking bench for the debug arm / trigger control block
// assumes dac_ctrl, dac_cfg.svh and the core model are compiled alongside
`include "dac_cfg.svh"
`default_nettype none
module debug_arm_trigger_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] CT = `DAC_OFS_CTRL;
    localparam logic [7:0] ST = `DAC_OFS_IRQST;
    localparam logic [7:0] MK = `DAC_OFS_IRQMSK;
    localparam logic [7:0] SQ = `DAC_OFS_SEQ;
    localparam logic [1:0] OK = `DAC_RESP_OKAY;
    localparam logic [1:0] SE = `DAC_RESP_SLV;

    logic        aclk = 1'h0;
    logic        aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, comparator_bank_select;
    logic        seq_step = 1'h0, trace_source_enable = 1'h0, trigger_alignment = 1'h0;
    logic        trace_begun = 1'h0, trace_complete = 1'h0, secure_mode = 1'h0;
    logic        cfg_en = 1'h0, cfg_act = 1'h0;
    logic [2:0]  seq_step_state = 3'h0, sequencer_state_flags;
    logic        background_mode_enable, background_active, armed, trace_trigger;
    logic        window_map_enable, match_flag_select, bdm_req, software_interrupt, irq;
    int          n_bdm, n_swi, n_immediate_trigger_request = 0, n_errors = 0, checks_done = 0;

    dac_ctrl u_dac_ctrl (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq_step, .seq_step_state,
        .trace_source_enable, .trigger_alignment, .trace_begun, .trace_complete, .secure_mode,
        .background_mode_enable, .background_active, .armed, .sequencer_state_flags,
        .trace_trigger, .comparator_bank_select, .window_map_enable, .match_flag_select,
        .bdm_req, .software_interrupt, .irq);

    dac_core_model u_dac_core_model (.aclk, .aresetn, .cfg_enable(cfg_en),
        .cfg_active(cfg_act), .bdm_req, .software_interrupt, .background_mode_enable,
        .background_active, .n_bdm, .n_swi);

    initial begin
        forever #10 aclk = ~aclk;
    end

    // trace start is a one-cycle pulse, so tally it every edge
    always @(posedge aclk) begin
        if (trace_trigger === 1'h1) n_immediate_trigger_request <= n_immediate_trigger_request + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        logic b_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        b_ok = 1'h0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!b_ok) begin
            @(posedge aclk);
            if (!aw_ok && s_axi_awready === 1'h1) begin
                aw_ok = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w_ok && s_axi_wready === 1'h1) begin
                w_ok = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
            if (s_axi_bvalid === 1'h1) begin
                b_ok = 1'h1;
                s_axi_bready <= 1'h0;
                chk({30'h0, s_axi_bresp}, {30'h0, er}, "write resp");
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input logic [1:0] er);
        logic done;
        done = 1'h0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                done = 1'h1;
                s_axi_rready <= 1'h0;
                chk(s_axi_rdata & m, exp, "read data");
                chk({30'h0, s_axi_rresp}, {30'h0, er}, "read resp");
            end
        end
    endtask : rd

    task automatic t_reset;
        rd(CT, 32'h0, '1, OK);
        rd(SQ, 32'h0, '1, OK);
        chk({30'h0, comparator_bank_select}, 32'h0, "reset bank");
        rd(8'h10, 32'h0, '1, SE);
        wr(8'h10, 8'hFF, SE);
        s_axi_wstrb <= 4'h0;
        wr(CT, 8'h1B, OK);
        s_axi_wstrb <= 4'hF;
        rd(CT, 32'h0, '1, OK);
        $display("test reset done");
    endtask : t_reset

    task automatic t_bank;
        for (int b = 0; b < 4; b++) begin
            wr(CT, 8'h18 | b[7:0], OK);
            rd(CT, 32'h18 | b, '1, OK);
            chk({30'h0, comparator_bank_select}, b, "bank");
            chk({30'h0, window_map_enable, match_flag_select}, (b == 3) ? 1 : 2, "map");
        end
        wr(CT, 8'h00, OK);
        $display("test bank done");
    endtask : t_bank

    task automatic t_route;
        logic [4:0] tab [4];
        int b0;
        int s0;
        // routing, enable, active, expected bdm, expected swi
        tab = '{5'h1A, 5'h11, 5'h01, 5'h0C};
        for (int i = 0; i < 4; i++) begin
            cfg_en <= tab[i][3];
            cfg_act <= tab[i][2];
            wr(CT, 8'h00, OK);
            wr(CT, {3'h0, tab[i][4], 4'h8}, OK);
            b0 = n_bdm;
            s0 = n_swi;
            wr(CT, {3'h6, tab[i][4], 4'h8}, OK);
            repeat (4) @(posedge aclk);
            chk(n_bdm - b0, tab[i][1], "bdm count");
            chk(n_swi - s0, tab[i][0], "swi count");
            if (i == 0) rd(SQ, 32'h0, '1, OK);
        end
        chk(n_immediate_trigger_request, 32'h0, "trace without source");
        cfg_en <= 1'h0;
        cfg_act <= 1'h0;
        $display("test route done");
    endtask : t_route

    task automatic t_trace;
        int s0;
        int t0;
        trace_source_enable <= 1'h1;
        wr(CT, 8'h00, OK);
        wr(CT, 8'h08, OK);
        s0 = n_swi;
        t0 = n_immediate_trigger_request;
        wr(CT, 8'hC8, OK);
        repeat (4) @(posedge aclk);
        chk(n_immediate_trigger_request - t0, 32'h1, "trace start");
        chk(n_swi - s0, 32'h0, "early brk");
        chk({31'h0, armed}, 32'h1, "still armed");
        trace_complete <= 1'h1;
        @(posedge aclk);
        trace_complete <= 1'h0;
        repeat (4) @(posedge aclk);
        chk(n_swi - s0, 32'h1, "brk after trace");
        rd(CT, 32'h08, '1, OK);
        rd(SQ, 32'h0, '1, OK);
        secure_mode <= 1'h1;
        t0 = n_immediate_trigger_request;
        wr(CT, 8'hC8, OK);
        repeat (4) @(posedge aclk);
        chk(n_immediate_trigger_request - t0, 32'h0, "secure trace");
        chk(n_swi - s0, 32'h2, "secure brk");
        secure_mode <= 1'h0;
        trace_source_enable <= 1'h0;
        $display("test trace done");
    endtask : t_trace

    task automatic t_armed;
        int b0;
        wr(CT, 8'h00, OK);
        wr(CT, 8'h80, OK);
        rd(SQ, 32'h81, '1, OK);
        seq_step_state <= 3'h2;
        seq_step <= 1'h1;
        @(posedge aclk);
        seq_step <= 1'h0;
        wr(CT, 8'h99, OK);
        rd(CT, 32'h81, '1, OK);
        rd(SQ, 32'h82, '1, OK);
        trigger_alignment <= 1'h1;
        trace_begun <= 1'h1;
        wr(CT, 8'hC1, OK);
        rd(SQ, 32'h82, '1, OK);
        trigger_alignment <= 1'h0;
        trace_begun <= 1'h0;
        b0 = n_bdm + n_swi;
        wr(CT, 8'hC1, OK);
        rd(SQ, 32'h84, '1, OK);
        chk(n_bdm + n_swi - b0, 32'h0, "no brk");
        wr(CT, 8'h01, OK);
        rd(CT, 32'h01, '1, OK);
        rd(SQ, 32'h04, '1, OK);
        chk({29'h0, sequencer_state_flags}, 32'h4, "flags pin");
        wr(CT, 8'h08, OK);
        wr(CT, 8'h88, OK);
        b0 = n_swi;
        seq_step_state <= 3'h4;
        seq_step <= 1'h1;
        @(posedge aclk);
        seq_step <= 1'h0;
        repeat (4) @(posedge aclk);
        chk(n_swi - b0, 32'h1, "step brk");
        rd(SQ, 32'h0, '1, OK);
        $display("test armed done");
    endtask : t_armed

    task automatic t_irq;
        rd(ST, 32'h1, 32'h1, OK);
        chk({31'h0, irq}, 32'h0, "masked irq");
        wr(MK, 8'h01, OK);
        chk({31'h0, irq}, 32'h1, "irq on");
        wr(ST, 8'h03, OK);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rd(ST, 32'h0, 32'h3, OK);
        wr(MK, 8'h00, OK);
        $display("test irq done");
    endtask : t_irq

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // the whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_bank;
        t_route;
        t_trace;
        t_armed;
        t_irq;
        end_of_test;
    end
endmodule : debug_arm_trigger_control_bench
`default_nettype wire
